// file: shared/msl_defines.svh
// timing counts and control constants for the master serial loader
`ifndef MSL_DEFINES_SVH
`define MSL_DEFINES_SVH
`define MSL_CLK_PERIOD_NS 4
`define MSL_RESTART_MIN_NS 500
`define MSL_RESTART_CYC ((`MSL_RESTART_MIN_NS + `MSL_CLK_PERIOD_NS - 1) / `MSL_CLK_PERIOD_NS)
`define MSL_CONFIG_CLOCK_OUT_HALF_CYC 6
`define MSL_CLEAR_CYC 64
`define MSL_MODE_MASTER_SERIAL 3'h0
`define MSL_CRC_W 16
`define MSL_CRC_POLY 16'h8005
`define MSL_APB_CTRL 12'h000
`define MSL_APB_STATUS 12'h004
`define MSL_APB_IRQ_STAT 12'h008
`define MSL_APB_IRQ_MASK 12'h00C
`define MSL_APB_BITCNT 12'h010
`define MSL_APB_CRC 12'h014
`define MSL_IRQ_DONE 0
`define MSL_IRQ_CRC_ERR 1
`define MSL_IRQ_RESTART 2
`define MSL_IRQ_BADMODE 3
`endif

// file: shared/msl_pkg.sv
// types for the master serial loader
`default_nettype none
package msl_pkg;
    typedef enum logic [2:0] {
        ST_RESTART,
        ST_CLEAR,
        ST_LOAD,
        ST_CHECK,
        ST_DONE,
        ST_ERROR,
        ST_IDLE
    } msl_state_e;

    typedef struct packed {
        logic config_clock_out;
        logic dout;
        logic init_oe;
        logic done_oe;
        logic pullup_en;
        logic pins_user;
    } msl_pins_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } msl_apb_rsp_s;
endpackage : msl_pkg
`default_nettype wire

// file: src/msl_loader.sv
// master serial configuration loader with apb status and control
// Function
// - all-zero mode select starts master serial load from serial memory.
// - config clock is generated internally and driven to the memory.
// - one bit captured on every rising config clock edge.
// - mode select sampled when init indicator is released high.
// - mode and pull-up select pins freed as user I/O after done.
// - pull-ups enabled during load when pull-up select is zero.
// - daisy output actively driven throughout configuration.
// - init indicator low while clearing, released at clearing end.
// - completion flag low during load, high only after success.
// - restart pulse of 500 ns or more clears and restarts loading.
// - crc error drives init indicator low.
`include "msl_defines.svh"
`default_nettype none
module msl_loader #(
    parameter int BITSTREAM_BITS = 1024,
    parameter int CLEAR_CYC = `MSL_CLEAR_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic program_restart_n_i,
    input wire logic [2:0] config_mode_select_i,
    input wire logic pullup_disable_select_i,
    input wire logic serial_config_in_i,
    input wire logic init_indicator_n_i,
    input wire logic done_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic config_clock_out_o,
    output logic config_clock_out_oe_o,
    output logic serial_daisy_out_o,
    output logic serial_daisy_out_oe_o,
    output logic init_indicator_n_o,
    output logic init_indicator_n_oe_o,
    output logic done_o,
    output logic done_oe_o,
    output logic user_pullup_en_o,
    output logic user_io_release_o,
    output logic irq_o
);
    localparam int RCW = $clog2(`MSL_RESTART_CYC + 1);

    typedef struct packed {
        msl_pkg::msl_state_e st;
        logic [1:0] prog_sync;
        logic [1:0] din_sync;
        logic [2:0] mode_s1;
        logic [2:0] mode_s2;
        logic hs_s1;
        logic hs_s2;
        logic [RCW-1:0] restart_cnt;
        logic restart_armed;
        logic [15:0] clear_cnt;
        logic [3:0] half_cnt;
        logic [31:0] bit_cnt;
        logic [`MSL_CRC_W-1:0] crc;
        logic [`MSL_CRC_W-1:0] crc_rx;
        logic [2:0] mode_latched;
        logic pullup_disable_select_latched;
        logic sw_restart;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        msl_pkg::msl_pins_s pins;
        msl_pkg::msl_apb_rsp_s apb;
        logic irq;
        logic drv_oe;
    } msl_reg_s;

    msl_reg_s r;
    msl_reg_s next_r;

    function automatic logic [`MSL_CRC_W-1:0] crc_step(input logic [`MSL_CRC_W-1:0] c,
                                                     input logic b);
        logic fb;
        fb = c[`MSL_CRC_W-1] ^ b;
        crc_step = {c[`MSL_CRC_W-2:0], 1'b0} ^ (fb ? `MSL_CRC_POLY : 16'h0000);
    endfunction : crc_step

    // an access to any other word answers with an error and reads as zero
    function automatic logic addr_mapped(input logic [11:0] a);
        unique case (a)
            `MSL_APB_CTRL,
            `MSL_APB_STATUS,
            `MSL_APB_IRQ_STAT,
            `MSL_APB_IRQ_MASK,
            `MSL_APB_BITCNT,
            `MSL_APB_CRC: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    logic apb_acc;
    logic apb_wr;
    logic [31:0] rd_val;
    logic [3:0] ev;
    logic config_clock_out_rise;
    logic restart_hit;
    logic [31:0] total_bits;

    always_comb begin
        next_r = r;
        ev = 4'h0;
        config_clock_out_rise = 1'b0;
        restart_hit = 1'b0;
        total_bits = 32'(BITSTREAM_BITS + `MSL_CRC_W);
        // pins from outside pass two flops before any use
        next_r.prog_sync = {r.prog_sync[0], program_restart_n_i};
        next_r.din_sync = {r.din_sync[0], serial_config_in_i};
        next_r.mode_s1 = config_mode_select_i;
        next_r.mode_s2 = r.mode_s1;
        next_r.hs_s1 = pullup_disable_select_i;
        next_r.hs_s2 = r.hs_s1;

        // restart pin: count a low pulse, act once it is long enough and rises
        if (!r.prog_sync[1]) begin
            if (r.restart_cnt != RCW'(`MSL_RESTART_CYC)) begin
                next_r.restart_cnt = r.restart_cnt + RCW'(1);
            end else begin
                next_r.restart_armed = 1'b1;
            end
        end else begin
            next_r.restart_cnt = '0;
            next_r.restart_armed = 1'b0;
            restart_hit = r.restart_armed || r.sw_restart;
        end
        next_r.sw_restart = 1'b0;

        unique case (r.st)
            msl_pkg::ST_RESTART: begin
                next_r.pins.init_oe = 1'b1;
                next_r.pins.done_oe = 1'b1;
                next_r.pins.config_clock_out = 1'b0;
                next_r.pins.pins_user = 1'b0;
                next_r.clear_cnt = '0;
                if (r.prog_sync[1]) begin
                    next_r.st = msl_pkg::ST_CLEAR;
                    ev[`MSL_IRQ_RESTART] = 1'b1;
                end
            end
            msl_pkg::ST_CLEAR: begin
                next_r.pins.init_oe = 1'b1;
                // hold off until the count ends and the restart pin reads high; the init input is not read
                if (r.clear_cnt != 16'(CLEAR_CYC - 1)) begin
                    next_r.clear_cnt = r.clear_cnt + 16'h0001;
                end else if (r.prog_sync[1]) begin
                    next_r.pins.init_oe = 1'b0;
                    next_r.mode_latched = r.mode_s2;
                    next_r.pullup_disable_select_latched = r.hs_s2;
                    next_r.bit_cnt = '0;
                    next_r.crc = '0;
                    next_r.crc_rx = '0;
                    next_r.half_cnt = '0;
                    if (r.mode_s2 == `MSL_MODE_MASTER_SERIAL) begin
                        next_r.st = msl_pkg::ST_LOAD;
                    end else begin
                        // other modes are not handled here
                        next_r.st = msl_pkg::ST_IDLE;
                        ev[`MSL_IRQ_BADMODE] = 1'b1;
                    end
                end
            end
            msl_pkg::ST_LOAD: begin
                // divided from the core clock, standing in for the oscillator
                if (r.half_cnt == 4'(`MSL_CONFIG_CLOCK_OUT_HALF_CYC - 1)) begin
                    next_r.half_cnt = '0;
                    next_r.pins.config_clock_out = !r.pins.config_clock_out;
                    config_clock_out_rise = !r.pins.config_clock_out;
                    // leave on a falling edge so the last high phase keeps its length
                    if (r.pins.config_clock_out && r.bit_cnt == total_bits) begin
                        next_r.st = msl_pkg::ST_CHECK;
                    end
                end else begin
                    next_r.half_cnt = r.half_cnt + 4'h1;
                end
                // data was presented after the previous rising edge, so it is settled
                if (config_clock_out_rise) begin
                    next_r.bit_cnt = r.bit_cnt + 32'h1;
                    next_r.pins.dout = r.din_sync[1];
                    if (r.bit_cnt < 32'(BITSTREAM_BITS)) begin
                        next_r.crc = crc_step(r.crc, r.din_sync[1]);
                    end else begin
                        next_r.crc_rx = {r.crc_rx[`MSL_CRC_W-2:0], r.din_sync[1]};
                    end
                end
            end
            msl_pkg::ST_CHECK: begin
                next_r.pins.config_clock_out = 1'b0;
                if (r.crc_rx == r.crc) begin
                    next_r.pins.done_oe = 1'b0;
                    next_r.pins.pins_user = 1'b1;
                    next_r.st = msl_pkg::ST_DONE;
                    ev[`MSL_IRQ_DONE] = 1'b1;
                end else begin
                    next_r.pins.init_oe = 1'b1;
                    next_r.st = msl_pkg::ST_ERROR;
                    ev[`MSL_IRQ_CRC_ERR] = 1'b1;
                end
            end
            msl_pkg::ST_DONE: begin
                next_r.pins.done_oe = 1'b0;
            end
            msl_pkg::ST_ERROR: begin
                next_r.pins.init_oe = 1'b1;
            end
            msl_pkg::ST_IDLE: begin
                next_r.pins.config_clock_out = 1'b0;
            end
            default: begin
                next_r.st = msl_pkg::ST_RESTART;
            end
        endcase

        if (restart_hit && r.st != msl_pkg::ST_RESTART) begin
            next_r.st = msl_pkg::ST_RESTART;
        end

        // a held restart pin overrides whatever the state machine chose
        if (!r.prog_sync[1]) begin
            next_r.st = msl_pkg::ST_RESTART;
        end

        // pull-ups follow the next state so they drop in the cycle done is released
        next_r.pins.pullup_en = (next_r.st == msl_pkg::ST_LOAD
                                 || next_r.st == msl_pkg::ST_CLEAR
                                 || next_r.st == msl_pkg::ST_CHECK) && !r.hs_s2;

        // apb: one wait state, pready is registered, access completes on second access-phase edge
        apb_acc = psel_i && penable_i && !r.apb.pready;
        apb_wr = apb_acc && pwrite_i;
        unique case (paddr_i)
            `MSL_APB_CTRL: rd_val = 32'h0;
            `MSL_APB_STATUS: rd_val = {21'h0, r.mode_latched, r.pullup_disable_select_latched,
                                       r.pins.pins_user, !r.pins.done_oe,
                                       !r.pins.init_oe, 1'b0, r.st};
            `MSL_APB_IRQ_STAT: rd_val = {28'h0, r.irq_stat};
            `MSL_APB_IRQ_MASK: rd_val = {28'h0, r.irq_mask};
            `MSL_APB_BITCNT: rd_val = r.bit_cnt;
            `MSL_APB_CRC: rd_val = {r.crc_rx, r.crc};
            default: rd_val = 32'h0;
        endcase
        next_r.apb.pready = apb_acc;
        next_r.apb.pslverr = apb_acc && !addr_mapped(paddr_i);
        next_r.apb.prdata = (apb_acc && !pwrite_i) ? rd_val : 32'h0;
        if (apb_wr && paddr_i == `MSL_APB_CTRL) begin
            next_r.sw_restart = pwdata_i[0];
        end
        if (apb_wr && paddr_i == `MSL_APB_IRQ_MASK) begin
            next_r.irq_mask = pwdata_i[3:0];
        end
        // set wins over write-one-to-clear
        if (apb_wr && paddr_i == `MSL_APB_IRQ_STAT) begin
            next_r.irq_stat = (r.irq_stat & ~pwdata_i[3:0]) | ev;
        end else begin
            next_r.irq_stat = r.irq_stat | ev;
        end
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
        // config pins stay driven until they are handed to the user
        next_r.drv_oe = !next_r.pins.pins_user;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            // restart pin synchroniser starts at its idle level: no false pulse
            r <= '{st: msl_pkg::ST_RESTART,
                   prog_sync: 2'h3,
                   drv_oe: 1'b1,
                   pins: '{init_oe: 1'b1, done_oe: 1'b1, default: 1'b0},
                   default: '0};
        end else begin
            r <= next_r;
        end
    end

    // every output is a flop except init_indicator_n_o and done_o, which are tied low
    assign prdata_o = r.apb.prdata;
    assign pready_o = r.apb.pready;
    assign pslverr_o = r.apb.pslverr;
    assign config_clock_out_o = r.pins.config_clock_out;
    assign config_clock_out_oe_o = r.drv_oe;
    assign serial_daisy_out_o = r.pins.dout;
    assign serial_daisy_out_oe_o = r.drv_oe;
    assign init_indicator_n_o = 1'b0;
    assign init_indicator_n_oe_o = r.pins.init_oe;
    assign done_o = 1'b0;
    assign done_oe_o = r.pins.done_oe;
    assign user_pullup_en_o = r.pins.pullup_en;
    assign user_io_release_o = r.pins.pins_user;
    assign irq_o = r.irq;
endmodule : msl_loader
`default_nettype wire

// file: bench/msl_loader_props.sv
// concurrent checks on the loader's pins and apb handshake
`default_nettype none
module msl_loader_props (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic program_restart_n_i,
    input wire logic pullup_disable_select_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic config_clock_out_o,
    input wire logic config_clock_out_oe_o,
    input wire logic serial_daisy_out_oe_o,
    input wire logic init_indicator_n_oe_o,
    input wire logic done_oe_o,
    input wire logic user_pullup_en_o,
    input wire logic user_io_release_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_done_rel; !done_oe_o |-> user_io_release_o; endproperty
    a_done_rel: assert property (p_done_rel) else $error("done without release");
    property p_daisy; !user_io_release_o |-> serial_daisy_out_oe_o; endproperty
    a_daisy: assert property (p_daisy) else $error("daisy out not driven");
    property p_config_clock_out_oe; !user_io_release_o |-> config_clock_out_oe_o; endproperty
    a_config_clock_out_oe: assert property (p_config_clock_out_oe) else $error("config clock not driven");
    property p_config_clock_out_half;
        $rose(config_clock_out_o) |=> $stable(config_clock_out_o) [*5];
    endproperty
    a_config_clock_out_half: assert property (p_config_clock_out_half) else $error("config clock too fast");
    // pin is only changed while restart is held, long before pull-ups come on
    property p_pullup; user_pullup_en_o |-> !$past(pullup_disable_select_i, 6); endproperty
    a_pullup: assert property (p_pullup) else $error("pull-ups on while disabled");
    property p_config_clock_out_init; $rose(config_clock_out_o) |-> !init_indicator_n_oe_o; endproperty
    a_config_clock_out_init: assert property (p_config_clock_out_init) else $error("clocking during clear");
    property p_pullup_off; $fell(done_oe_o) |-> !user_pullup_en_o; endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-ups on after done");
    property p_done_init; $fell(done_oe_o) |-> !init_indicator_n_oe_o; endproperty
    a_done_init: assert property (p_done_init) else $error("done with init low");
    property p_restart;
        !program_restart_n_i [*6] |=> init_indicator_n_oe_o && done_oe_o;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not honoured");
    property p_apb_ans; psel_i && penable_i && !pready_o |=> pready_o; endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("apb answer late");
    property p_apb_pulse; pready_o |=> !pready_o; endproperty
    a_apb_pulse: assert property (p_apb_pulse) else $error("pready longer than one cycle");
endmodule : msl_loader_props
bind msl_loader msl_loader_props u_props (.mclk_i(mclk_i), .rst_i(rst_i),
    .program_restart_n_i(program_restart_n_i),
    .pullup_disable_select_i(pullup_disable_select_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .config_clock_out_o(config_clock_out_o),
    .config_clock_out_oe_o(config_clock_out_oe_o),
    .serial_daisy_out_oe_o(serial_daisy_out_oe_o),
    .init_indicator_n_oe_o(init_indicator_n_oe_o), .done_oe_o(done_oe_o),
    .user_pullup_en_o(user_pullup_en_o), .user_io_release_o(user_io_release_o));
`default_nettype wire

// file: bench/msl_prom_model.sv
// serial configuration memory: data bits then crc-16, msb first
`default_nettype none
module msl_prom_model #(
    parameter int N = 16
) (
    input wire logic config_clock_out_i,
    input wire logic en_i,
    input wire logic bad_i,
    output logic data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] crc;
    int idx;
    logic cur;
    logic last;
    // past the crc word the line rests low instead of indexing outside the register
    always_comb cur = (idx < N) ? (idx[0] ^ idx[2])
                    : (idx < N + 16) ? (crc[15 - (idx - N)] ^ bad_i) : 1'b0;
    // advance at the rising edge; the loader has already sampled the old bit
    always @(posedge config_clock_out_i or negedge en_i) begin
        if (!en_i) begin
            idx <= 0;
            crc <= 16'h0000;
        end else begin
            if (idx < N) crc <= {crc[14:0], 1'b0} ^ ((crc[15] ^ cur) ? 16'h8005 : 16'h0000);
            idx <= idx + 1;
        end
    end
    // disabled memory leaves no trustworthy level on the line
    always @(negedge en_i) last <= cur;
    assign data_o = en_i ? cur : ~last;
endmodule : msl_prom_model
`default_nettype wire

// file: bench/msl_loader_test.sv
// apb-driven tests of the master serial loader
`default_nettype none
module msl_loader_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, prog_n, pus, sdin, bad, psel, penable, pwrite;
    logic [2:0] mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, slv, config_clock_out, config_clock_out_oe, dout, dout_oe, init_oe, done_oe, pu_en, rel;
    logic irq, irq_a, bit_seen;
    int err_total, cmp_count;
    msl_loader #(.BITSTREAM_BITS(16), .CLEAR_CYC(8)) DUT (.mclk_i(clk), .rst_i(rst),
        .program_restart_n_i(prog_n), .config_mode_select_i(mode),
        .pullup_disable_select_i(pus), .serial_config_in_i(sdin),
        .init_indicator_n_i(!init_oe), .done_i(!done_oe), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .config_clock_out_o(config_clock_out),
        .config_clock_out_oe_o(config_clock_out_oe), .serial_daisy_out_o(dout),
        .serial_daisy_out_oe_o(dout_oe), .init_indicator_n_o(), .init_indicator_n_oe_o(init_oe),
        .done_o(), .done_oe_o(done_oe), .user_pullup_en_o(pu_en), .user_io_release_o(rel),
        .irq_o(irq));
    msl_prom_model #(.N(16)) u_prom (.config_clock_out_i(config_clock_out), .en_i(!init_oe && done_oe),
        .bad_i(bad), .data_o(sdin));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // bit on the data line at each rising config clock, as the loader must take it
    always @(posedge config_clock_out) bit_seen <= sdin;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        // a slave that never answers counts against the run
        if (pready !== 1'b1) err_total++;
        rd = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic wait_lvl(input bit d, input logic v);
        for (int k = 0; k < 3000 && (d ? done_oe : init_oe) !== v; k++) @(posedge clk);
        chk(32'(d ? done_oe : init_oe), 32'(v));
    endtask : wait_lvl
    task automatic restart(input logic [2:0] m, input logic p, input logic b);
        prog_n <= 0;
        mode <= m;
        pus <= p;
        bad <= b;
        repeat (130) @(posedge clk);
        prog_n <= 1;
        wait_lvl(0, 1'b0);
    endtask : restart
    task print_verdict;
        $display("mismatches=%0d compares=%0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict();
    end
    initial begin
        rst = 1;
        prog_n = 1;
        mode = 3'h0;
        pus = 0;
        bad = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge clk);
        rst <= 0;
        wait_lvl(0, 1'b0);
        chk(32'(pu_en), 32'h1);
        wait_lvl(1, 1'b0);
        chk(32'({rel, dout_oe, config_clock_out_oe, pu_en}), 32'h8);
        chk(32'(dout), 32'(bit_seen));
        apb(0, 12'h004, 32'h0);
        chk(rd & 32'h7F7, 32'h74);
        apb(0, 12'h008, 32'h0);
        chk(rd & 32'hB, 32'h1);
        // mask polarity is the designer's; only the difference is checked
        apb(1, 12'h00C, 32'hF);
        repeat (2) @(posedge clk);
        irq_a = irq;
        apb(1, 12'h00C, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq_a ^ irq), 32'h1);
        apb(1, 12'h008, 32'hF);
        apb(0, 12'h008, 32'h0);
        chk(rd & 32'hB, 32'h0);
        chk(32'(irq), 32'h0);
        apb(0, 12'hFF0, 32'h0);
        chk({rd[30:0], slv}, 32'h1);
        restart(3'h0, 1, 1);
        chk(32'(pu_en), 32'h0);
        wait_lvl(0, 1'b1);
        chk(32'({done_oe, rel}), 32'h2);
        apb(0, 12'h004, 32'h0);
        chk(rd & 32'h7, 32'h5);
        apb(0, 12'h008, 32'h0);
        chk(rd & 32'h2, 32'h2);
        restart(3'h5, 0, 0);
        mode <= 3'h0;
        repeat (50) @(posedge clk);
        apb(0, 12'h004, 32'h0);
        chk(rd & 32'h707, 32'h506);
        chk(32'({done_oe, rel}), 32'h2);
        apb(0, 12'h008, 32'h0);
        chk(rd & 32'h8, 32'h8);
        // software restart from the control word reloads with the new mode
        apb(1, 12'h000, 32'h1);
        wait_lvl(1, 1'b0);
        chk(32'({rel, pu_en}), 32'h2);
        apb(0, 12'h008, 32'h0);
        chk(rd & 32'h5, 32'h5);
        print_verdict();
    end
endmodule : msl_loader_test
`default_nettype wire
